// ### src/epwm_output_stage.sv
// Enhanced PWM output stage with time base, dead band, pin routing and AXI4-Lite registers
// Notes on behaviour
// - PWM timing is counted from core_clk, so its rate scales with that clock.
// - Reset makes every pin an input and restores all registers.
// - Alternate pin select bits move each output to its alternate pin.
// - Config 10 half-bridge, 01 forward, 11 reverse, 00 single.
// - Half-bridge drives A and B; full-bridge all four; single follows steering.
// - Up to four outputs carry the signal with ten-bit duty resolution.
// - Mode polarity field sets the active level of pins A/C and B/D.
// - After enable, outputs wait for the next full period before modulating.
// - Writing zero to module_control releases all pins.
// - A pin is driven only while its direction bit is cleared.
// - Pins unused by the configuration stay released.
// - Time base is the 8-bit count with two low prescaler or quarter bits.
// - Half-bridge puts the signal on A and its complement on B.
// - Half-bridge delays activation by dead-band count times four clocks.
// - Dead band longer than the active time keeps that output inactive.
// - Dead band applies only to activating edges.
// - At period match the count clears, output sets unless zero duty, duty latches.
// - Pulse ends when the time base equals the latched duty.
`timescale 1ns/100ps
`include "epwm_regs.svh"

module epwm_output_stage #(
  parameter int PINS = 4
) (
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output logic [PINS-1:0]      pinOut,
  output logic [PINS-1:0]      pinOe,
  output logic [PINS-1:0]      altPinOut,
  output logic [PINS-1:0]      altPinOe
);
  import epwm_pkg::*;

  // Prescaler terminal count: one less than the clocks per timer tick, which are four times the ratio
  function automatic logic [5:0] prescLimit(input logic [1:0] ps);
    if (ps == `EPWM_PS_ONE) begin
      prescLimit = `EPWM_LIM_ONE;
    end else if (ps == `EPWM_PS_FOUR) begin
      prescLimit = `EPWM_LIM_FOUR;
    end else begin
      prescLimit = `EPWM_LIM_SIXTEEN;
    end
  endfunction : prescLimit

  // Two low time-base bits taken from the top of the running prescaler
  function automatic logic [1:0] lowBits(input logic [1:0] ps, input logic [5:0] pc);
    if (ps == `EPWM_PS_ONE) begin
      lowBits = pc[1:0];
    end else if (ps == `EPWM_PS_FOUR) begin
      lowBits = pc[3:2];
    end else begin
      lowBits = pc[5:4];
    end
  endfunction : lowBits

  logic [7:0]            modCtl_ff;
  logic [7:0]            dutyHigh_ff;
  logic [7:0]            period_ff;
  logic [6:0]            tbCtl_ff;
  logic [7:0]            tbCount_ff;
  logic [7:0]            dbCtl_ff;
  logic [3:0]            steer_ff;
  logic [3:0]            altSel_ff;
  logic [7:0]            tmrSel_ff;
  logic [3:0]            pinDir_ff;
  logic [9:0]            dutyLatch_ff;
  logic [5:0]            presc_ff;
  logic                  pwmRaw_ff;
  logic                  started_ff;
  logic [8:0]            dbCnt_ff [2];
  logic [PINS-1:0]       dbOut_ff;
  logic                  awHeld_ff;
  logic                  wHeld_ff;
  logic [7:0]            awAddr_ff;
  logic [31:0]           wData_ff;
  logic [3:0]            wStrb_ff;
  logic                  nxt_awHeld;
  logic                  nxt_wHeld;
  logic                  nxt_bvalid;
  logic                  doWrite;
  logic                  wrLane;
  logic [7:0]            wrByte;
  logic                  wrHit;
  logic [31:0]           rdMux;
  logic                  rdHit;
  epwm_cfg_t             cfg;
  logic                  pwmEnabled;
  logic                  tick;
  logic                  rollover;
  logic [9:0]            timeBase;
  logic [9:0]            newDuty;
  logic                  modSig;
  logic                  pulse;
  logic [PINS-1:0]       want;
  logic [PINS-1:0]       used;
  logic [PINS-1:0]       activeLow;
  logic [PINS-1:0]       drive;
  logic [8:0]            dbLimit;

  // Write channel bookkeeping: address and data may arrive in either order
  always_comb begin
    doWrite    = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    nxt_awHeld = (awHeld_ff || (s_axi_awvalid && s_axi_awready)) && !doWrite;
    nxt_wHeld  = (wHeld_ff || (s_axi_wvalid && s_axi_wready)) && !doWrite;
    nxt_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
    wrLane     = doWrite && wStrb_ff[0];
    wrByte     = wData_ff[7:0];
  end

  // Write address, data and response handshake
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      awHeld_ff     <= 1'b0;
      wHeld_ff      <= 1'b0;
      awAddr_ff     <= `EPWM_RST_BYTE;
      wData_ff      <= 32'h0000_0000;
      wStrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      awHeld_ff     <= nxt_awHeld;
      wHeld_ff      <= nxt_wHeld;
      s_axi_awready <= !nxt_awHeld && !nxt_bvalid;
      s_axi_wready  <= !nxt_wHeld && !nxt_bvalid;
      s_axi_bvalid  <= nxt_bvalid;
      if (doWrite) begin
        s_axi_bresp <= wrHit ? `EPWM_RESP_OKAY : `EPWM_RESP_SLVERR;
      end
    end
  end

  // Write address decode
  always_comb begin
    if (awAddr_ff == `EPWM_OFF_MOD_CTL || awAddr_ff == `EPWM_OFF_DUTY_HIGH || awAddr_ff == `EPWM_OFF_PERIOD) begin
      wrHit = 1'b1;
    end else if (awAddr_ff == `EPWM_OFF_TB_CTL || awAddr_ff == `EPWM_OFF_TB_COUNT || awAddr_ff == `EPWM_OFF_DB_CTL) begin
      wrHit = 1'b1;
    end else if (awAddr_ff == `EPWM_OFF_STEER || awAddr_ff == `EPWM_OFF_ALT_SEL || awAddr_ff == `EPWM_OFF_TMR_SEL) begin
      wrHit = 1'b1;
    end else if (awAddr_ff == `EPWM_OFF_PIN_DIR || awAddr_ff == `EPWM_OFF_SHADOW || awAddr_ff == `EPWM_OFF_STATUS) begin
      wrHit = 1'b1;
    end else begin
      wrHit = 1'b0;
    end
  end

  // Software registers; all return to reset values on reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      modCtl_ff   <= `EPWM_RST_BYTE;
      dutyHigh_ff <= `EPWM_RST_BYTE;
      period_ff   <= `EPWM_RST_BYTE;
      tbCtl_ff    <= {`EPWM_TB_CTL_BITS{1'b0}};
      dbCtl_ff    <= `EPWM_RST_BYTE;
      steer_ff    <= `EPWM_RST_NIBBLE;
      altSel_ff   <= `EPWM_RST_NIBBLE;
      tmrSel_ff   <= `EPWM_RST_BYTE;
      pinDir_ff   <= `EPWM_RST_PIN_DIR;
    end else if (wrLane) begin
      if (awAddr_ff == `EPWM_OFF_MOD_CTL) begin
        modCtl_ff <= wrByte;
      end else if (awAddr_ff == `EPWM_OFF_DUTY_HIGH) begin
        dutyHigh_ff <= wrByte;
      end else if (awAddr_ff == `EPWM_OFF_PERIOD) begin
        period_ff <= wrByte;
      end else if (awAddr_ff == `EPWM_OFF_TB_CTL) begin
        tbCtl_ff <= wrByte[`EPWM_TB_CTL_BITS-1:0];
      end else if (awAddr_ff == `EPWM_OFF_DB_CTL) begin
        dbCtl_ff <= wrByte;
      end else if (awAddr_ff == `EPWM_OFF_STEER) begin
        steer_ff <= wrByte[3:0];
      end else if (awAddr_ff == `EPWM_OFF_ALT_SEL) begin
        altSel_ff <= wrByte[3:0];
      end else if (awAddr_ff == `EPWM_OFF_TMR_SEL) begin
        tmrSel_ff <= wrByte;
      end else if (awAddr_ff == `EPWM_OFF_PIN_DIR) begin
        pinDir_ff <= wrByte[3:0];
      end
    end
  end

  // Read data mux; reserved bits read zero
  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    if (s_axi_araddr == `EPWM_OFF_MOD_CTL) begin
      rdMux[7:0] = modCtl_ff;
    end else if (s_axi_araddr == `EPWM_OFF_DUTY_HIGH) begin
      rdMux[7:0] = dutyHigh_ff;
    end else if (s_axi_araddr == `EPWM_OFF_PERIOD) begin
      rdMux[7:0] = period_ff;
    end else if (s_axi_araddr == `EPWM_OFF_TB_CTL) begin
      rdMux[6:0] = tbCtl_ff;
    end else if (s_axi_araddr == `EPWM_OFF_TB_COUNT) begin
      rdMux[7:0] = tbCount_ff;
    end else if (s_axi_araddr == `EPWM_OFF_DB_CTL) begin
      rdMux[7:0] = dbCtl_ff;
    end else if (s_axi_araddr == `EPWM_OFF_STEER) begin
      rdMux[3:0] = steer_ff;
    end else if (s_axi_araddr == `EPWM_OFF_ALT_SEL) begin
      rdMux[3:0] = altSel_ff;
    end else if (s_axi_araddr == `EPWM_OFF_TMR_SEL) begin
      rdMux[7:0] = tmrSel_ff;
    end else if (s_axi_araddr == `EPWM_OFF_PIN_DIR) begin
      rdMux[3:0] = pinDir_ff;
    end else if (s_axi_araddr == `EPWM_OFF_SHADOW) begin
      rdMux[9:0] = dutyLatch_ff;
    end else if (s_axi_araddr == `EPWM_OFF_STATUS) begin
      rdMux[5:0] = {started_ff, pwmRaw_ff, dbOut_ff};
    end else begin
      rdHit = 1'b0;
    end
  end

  // Read address and data handshake
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `EPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdHit ? `EPWM_RESP_OKAY : `EPWM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Time base decode
  always_comb begin
    cfg        = epwm_cfg_t'(modCtl_ff[`EPWM_CFG_HI:`EPWM_CFG_LO]);
    pwmEnabled = modCtl_ff[`EPWM_PWM_MODE_HI:`EPWM_PWM_MODE_LO] == `EPWM_PWM_MODE_CODE;
    tick       = tbCtl_ff[`EPWM_RUN_BIT] && (presc_ff == prescLimit(tbCtl_ff[`EPWM_PS_HI:`EPWM_PS_LO]));
    rollover   = tick && (tbCount_ff == period_ff);
    timeBase   = {tbCount_ff, lowBits(tbCtl_ff[`EPWM_PS_HI:`EPWM_PS_LO], presc_ff)};
    newDuty    = {dutyHigh_ff, modCtl_ff[`EPWM_DLOW_HI:`EPWM_DLOW_LO]};
  end

  // Prescaler and timer count; a software write to the count wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      presc_ff   <= `EPWM_RST_PRESC;
      tbCount_ff <= `EPWM_RST_BYTE;
    end else begin
      if (tick) begin
        presc_ff <= `EPWM_RST_PRESC;
      end else if (tbCtl_ff[`EPWM_RUN_BIT]) begin
        presc_ff <= presc_ff + 6'h01;
      end
      if (wrLane && awAddr_ff == `EPWM_OFF_TB_COUNT) begin
        tbCount_ff <= wrByte;
      end else if (rollover) begin
        tbCount_ff <= `EPWM_RST_BYTE;
      end else if (tick) begin
        tbCount_ff <= tbCount_ff + 8'h01;
      end
    end
  end

  // Duty latch and raw pulse: set at period start, cleared at duty match
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dutyLatch_ff <= `EPWM_RST_DUTY;
      pwmRaw_ff    <= 1'b0;
    end else if (rollover) begin
      dutyLatch_ff <= newDuty;
      pwmRaw_ff    <= newDuty != `EPWM_RST_DUTY;
    end else if (timeBase == dutyLatch_ff) begin
      pwmRaw_ff <= 1'b0;
    end
  end

  // Generation waits for the first full period after enable
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      started_ff <= 1'b0;
    end else if (!pwmEnabled) begin
      started_ff <= 1'b0;
    end else if (rollover) begin
      started_ff <= 1'b1;
    end
  end

  // Output configuration: undelayed active states and pins in use
  always_comb begin
    // Mask the match cycle so the pulse lasts exactly the duty value in time-base units
    pulse     = pwmRaw_ff && (timeBase != dutyLatch_ff);
    modSig    = pulse && started_ff;
    want      = '0;
    used      = '0;
    activeLow = {modCtl_ff[`EPWM_POL_BD], modCtl_ff[`EPWM_POL_AC], modCtl_ff[`EPWM_POL_BD],
                 modCtl_ff[`EPWM_POL_AC]};
    case (cfg)
      EPWM_CFG_HALF: begin
        want = {2'b00, started_ff && !pulse, modSig};
        used = 4'h3;
      end
      EPWM_CFG_FWD: begin
        want = {modSig, 2'b00, started_ff};
        used = 4'hF;
      end
      EPWM_CFG_REV: begin
        want = {1'b0, started_ff, modSig, 1'b0};
        used = 4'hF;
      end
      default: begin
        want = steer_ff & {PINS{modSig}};
        used = steer_ff;
      end
    endcase
    dbLimit = {dbCtl_ff[`EPWM_DB_BITS-1:0], 2'b00};
  end

  // Dead-band counters, one per half-bridge output, reset on every deactivation
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        dbCnt_ff[i] <= 9'h000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!want[i]) begin
          dbCnt_ff[i] <= 9'h000;
        end else if (dbCnt_ff[i] < dbLimit) begin
          dbCnt_ff[i] <= dbCnt_ff[i] + 9'h001;
        end
      end
    end
  end

  // Delayed active states; a dead band longer than the pulse never activates
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dbOut_ff <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (cfg == EPWM_CFG_HALF && i < 2) begin
          dbOut_ff[i] <= want[i] && (dbCnt_ff[i] >= dbLimit);
        end else begin
          dbOut_ff[i] <= want[i];
        end
      end
    end
  end

  // Pin drive gating: ownership, use and direction
  always_comb begin
    drive = used & ~pinDir_ff & {PINS{pwmEnabled}};
  end

  // Registered pins, routed to primary or alternate position
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pinOut    <= '0;
      pinOe     <= '0;
      altPinOut <= '0;
      altPinOe  <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pinOut[i]    <= !altSel_ff[i] && (dbOut_ff[i] ^ activeLow[i]);
        pinOe[i]     <= !altSel_ff[i] && drive[i];
        altPinOut[i] <= altSel_ff[i] && (dbOut_ff[i] ^ activeLow[i]);
        altPinOe[i]  <= altSel_ff[i] && drive[i];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence riseOne;
    $rose(want[0]) && cfg == EPWM_CFG_HALF && dbCtl_ff[6:0] == 7'd1;
  endsequence

  chk_pins_after_reset: assert property ($rose(rst_b) |-> pinOe == '0 && altPinOe == '0)
    else $error("pins driven right after reset");
  chk_release_on_zero: assert property (modCtl_ff == 8'h00 |=> pinOe == '0 && altPinOe == '0)
    else $error("pins still driven with module_control zero");
  chk_dir_gates_pin: assert property (pinDir_ff[0] |=> !pinOe[0] && !altPinOe[0])
    else $error("pin A driven while direction is input");
  chk_half_unused_pins: assert property (cfg == EPWM_CFG_HALF |=> !pinOe[2] && !pinOe[3])
    else $error("unused pin driven in half-bridge");
  chk_duty_latched: assert property (rollover |=> dutyLatch_ff == $past(newDuty))
    else $error("duty not latched at period end");
  chk_zero_duty_low: assert property (rollover && newDuty == 10'h000 |=> !pwmRaw_ff)
    else $error("pulse set with zero duty");
  chk_pulse_end: assert property (pwmRaw_ff && !rollover && timeBase == dutyLatch_ff |=> !pwmRaw_ff)
    else $error("pulse not ended at duty match");
  chk_start_at_period: assert property ($rose(started_ff) |-> $past(rollover) && $past(pwmEnabled))
    else $error("generation started mid period");
  chk_deadband_hold: assert property (riseOne |=> !dbOut_ff[0] [*4])
    else $error("output A activated inside dead band");
  chk_deadband_end: assert property (riseOne ##1 (want[0] && dbCtl_ff[6:0] == 7'd1) [*4] |=> dbOut_ff[0])
    else $error("output A not active after dead band");
  chk_fall_undelayed: assert property (!want[1] |=> !dbOut_ff[1])
    else $error("deactivating edge of B delayed");

endmodule : epwm_output_stage

// ### src/epwm_pkg.sv
// Types shared by the enhanced PWM output stage
package epwm_pkg;
  typedef enum logic [1:0] {
    EPWM_CFG_SINGLE = 2'b00,
    EPWM_CFG_FWD    = 2'b01,
    EPWM_CFG_HALF   = 2'b10,
    EPWM_CFG_REV    = 2'b11
  } epwm_cfg_t;
endpackage : epwm_pkg

// ### src/epwm_regs.svh
// Register offsets, field positions, reset values and timing counts of the enhanced PWM output stage
`ifndef EPWM_REGS_SVH
`define EPWM_REGS_SVH

// Byte offsets on the register bus
`define EPWM_OFF_MOD_CTL    8'h00
`define EPWM_OFF_DUTY_HIGH  8'h04
`define EPWM_OFF_PERIOD     8'h08
`define EPWM_OFF_TB_CTL     8'h0C
`define EPWM_OFF_TB_COUNT   8'h10
`define EPWM_OFF_DB_CTL     8'h14
`define EPWM_OFF_STEER      8'h18
`define EPWM_OFF_ALT_SEL    8'h1C
`define EPWM_OFF_TMR_SEL    8'h20
`define EPWM_OFF_PIN_DIR    8'h24
`define EPWM_OFF_SHADOW     8'h28
`define EPWM_OFF_STATUS     8'h2C

// Reset values
`define EPWM_RST_BYTE       8'h00
`define EPWM_RST_NIBBLE     4'h0
`define EPWM_RST_PIN_DIR    4'hF
`define EPWM_RST_DUTY       10'h000
`define EPWM_RST_PRESC      6'h00

// Fields of module_control
`define EPWM_CFG_HI         7
`define EPWM_CFG_LO         6
`define EPWM_DLOW_HI        5
`define EPWM_DLOW_LO        4
`define EPWM_PWM_MODE_HI    3
`define EPWM_PWM_MODE_LO    2
`define EPWM_POL_AC         1
`define EPWM_POL_BD         0
`define EPWM_PWM_MODE_CODE  2'h3

// Fields of timebase_control
`define EPWM_RUN_BIT        2
`define EPWM_PS_HI          1
`define EPWM_PS_LO          0
`define EPWM_TB_CTL_BITS    7

// Dead-band field width and prescaler terminal counts
`define EPWM_DB_BITS        7
`define EPWM_PS_ONE         2'h0
`define EPWM_PS_FOUR        2'h1
`define EPWM_LIM_ONE        6'h03
`define EPWM_LIM_FOUR       6'h0F
`define EPWM_LIM_SIXTEEN    6'h3F

// AXI responses
`define EPWM_RESP_OKAY      2'h0
`define EPWM_RESP_SLVERR    2'h2

`endif

// ### tb/epwm_output_stage_tb_top.sv
// Self-checking testbench of the enhanced PWM output stage
`timescale 1ns/100ps
`include "epwm_regs.svh"
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module epwm_output_stage_tb_top;
  typedef struct packed {
    logic [7:0]  mc;
    logic [7:0]  db;
    logic [7:0]  st;
    logic [7:0]  dh;
    logic [3:0]  oe;
    logic [31:0] cnt;
  } epwm_row_t;

  logic            core_clk, rst_b, measEn;
  logic [7:0]      awAddr, arAddr;
  logic [31:0]     wData, rData, rd;
  logic            awValid, wValid, bReady, arValid, rReady;
  logic            awReady, wReady, bValid, arReady, rValid;
  logic [1:0]      bResp, rResp, rs;
  logic [3:0]      pinOut, pinOe, altPinOut, altPinOe;
  logic [3:0][7:0] hiCnt;
  int              nMismatch, numChecks, cycCnt;

  // Register rows: address, write byte, read byte, response
  logic [25:0] regRows [4] = '{{8'h08, 8'hA5, 8'hA5, 2'h0}, {8'h0C, 8'hFB, 8'h7B, 2'h0},
                               {8'h28, 8'h55, 8'h00, 2'h0}, {8'h30, 8'h12, 8'h00, 2'h2}};
  // Output rows: control, dead band, steering, duty high, enables, high counts D..A
  epwm_row_t rows [9] = '{
    {8'h8C, 8'h00, 8'h00, 8'h02, 4'h3, 32'h0000_2020}, {8'h9C, 8'h00, 8'h00, 8'h02, 4'h3, 32'h0000_1C24},
    {8'h8C, 8'h01, 8'h00, 8'h02, 4'h3, 32'h0000_1010}, {8'h8C, 8'h03, 8'h00, 8'h02, 4'h3, 32'h0000_0000},
    {8'h8F, 8'h01, 8'h00, 8'h02, 4'h3, 32'h0000_3030}, {8'h4C, 8'h00, 8'h00, 8'h02, 4'hF, 32'h2000_0040},
    {8'hCC, 8'h00, 8'h00, 8'h02, 4'hF, 32'h0040_2000}, {8'h0C, 8'h00, 8'h05, 8'h02, 4'h5, 32'h0020_0020},
    {8'h8C, 8'h00, 8'h00, 8'h00, 4'h3, 32'h0000_4000}};

  epwm_output_stage DUT (
    .core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pinOut(pinOut), .pinOe(pinOe), .altPinOut(altPinOut), .altPinOe(altPinOe)
  );

  epwm_switch_model #(.N(4)) switches (
    .core_clk(core_clk), .rst_b(rst_b), .drvOut(pinOut), .drvOe(pinOe),
    .measEn(measEn), .hiCnt(hiCnt)
  );

  // Clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 6000) begin
      nMismatch++;
      wrap_up();
    end
  end

  // One register write; address and data released as each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awAddr <= a;
    wData <= {24'h00_0000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid && bReady) begin
        r = bResp;
        bReady <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  // One register read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid && rReady) begin
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Settle a few cycles, then look between edges
  task automatic settle();
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  // Counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {awValid, wValid, bReady, arValid, rReady, measEn} = '0;
    {awAddr, arAddr, wData} = '0;
    {nMismatch, numChecks, cycCnt} = '0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    `CHK({altPinOe, pinOe}, 8'h00)
    axi_rd(`EPWM_OFF_PIN_DIR, rd, rs);
    `CHK(rd, 32'h0000_000F)
    foreach (regRows[i]) begin
      axi_wr(regRows[i][25:18], regRows[i][17:10], rs);
      `CHK(rs, regRows[i][1:0])
      axi_rd(regRows[i][25:18], rd, rs);
      `CHK({rs, rd}, {regRows[i][1:0], 24'h00_0000, regRows[i][9:2]})
    end
    $display("register test done");
    // Timer: prescale 1, period 4 ticks, count restarted, pins to outputs
    axi_wr(`EPWM_OFF_TB_CTL, 8'h04, rs);
    axi_wr(`EPWM_OFF_PERIOD, 8'h03, rs);
    axi_wr(`EPWM_OFF_TB_COUNT, 8'h00, rs);
    axi_wr(`EPWM_OFF_PIN_DIR, 8'h00, rs);
    foreach (rows[i]) begin
      axi_wr(`EPWM_OFF_DUTY_HIGH, rows[i].dh, rs);
      axi_wr(`EPWM_OFF_DB_CTL, rows[i].db, rs);
      axi_wr(`EPWM_OFF_STEER, rows[i].st, rs);
      axi_wr(`EPWM_OFF_MOD_CTL, rows[i].mc, rs);
      repeat (48) @(posedge core_clk);
      measEn <= 1'b1;
      repeat (64) @(posedge core_clk);
      measEn <= 1'b0;
      @(negedge core_clk);
      `CHK(hiCnt, rows[i].cnt)
      `CHK(pinOe, rows[i].oe)
      axi_rd(`EPWM_OFF_SHADOW, rd, rs);
      `CHK(rd, {22'h00_0000, rows[i].dh, rows[i].mc[5:4]})
      $display("output row %0d done", i);
    end
    // Prescale 4: period 64 clocks, duty 8 units of four clocks each
    axi_wr(`EPWM_OFF_DUTY_HIGH, 8'h02, rs);
    axi_wr(`EPWM_OFF_TB_CTL, 8'h05, rs);
    repeat (128) @(posedge core_clk);
    measEn <= 1'b1;
    repeat (64) @(posedge core_clk);
    measEn <= 1'b0;
    @(negedge core_clk);
    `CHK(hiCnt, 32'h0000_2020)
    $display("prescale test done");
    // A moved to its alternate pin, B left as input
    axi_wr(`EPWM_OFF_ALT_SEL, 8'h01, rs);
    axi_wr(`EPWM_OFF_PIN_DIR, 8'h02, rs);
    settle();
    `CHK(altPinOe, 4'h1)
    `CHK(pinOe, 4'h0)
    axi_wr(`EPWM_OFF_MOD_CTL, 8'h00, rs);
    settle();
    `CHK({altPinOe, pinOe}, 8'h00)
    $display("pin routing test done");
    // Reset in mid-run while the alternate pin is driven
    axi_wr(`EPWM_OFF_MOD_CTL, 8'h8C, rs);
    settle();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    `CHK({altPinOe, pinOe}, 8'h00)
    axi_rd(`EPWM_OFF_ALT_SEL, rd, rs);
    `CHK(rd, 32'h0000_0000)
    axi_rd(`EPWM_OFF_MOD_CTL, rd, rs);
    `CHK(rd, 32'h0000_0000)
    $display("second reset test done");
    wrap_up();
  end
endmodule : epwm_output_stage_tb_top

// ### tb/epwm_switch_model.sv
// Power switch driver model: resolves pad levels and counts driven-high cycles
`timescale 1ns/100ps

module epwm_switch_model #(
  parameter int N = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] drvOut,
  input  wire logic [N-1:0] drvOe,
  input  wire logic         measEn,
  output logic [N-1:0][7:0] hiCnt
);
  logic [N-1:0] padLast_ff;
  logic [N-1:0] padLvl;

  // A released pad floats, so it shows the inverse of its last level
  assign padLvl = (drvOe & drvOut) | (~drvOe & ~padLast_ff);

  // Last pad level seen by the switch inputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) padLast_ff <= '0;
    else padLast_ff <= padLvl;
  end

  // Count cycles in which each switch input is driven high
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < N; i++) begin
      if (!measEn) hiCnt[i] <= 8'h00;
      else if (drvOe[i] && padLvl[i]) hiCnt[i] <= hiCnt[i] + 8'h01;
    end
  end
endmodule : epwm_switch_model
